// ==== verilog/iss_top.v ====
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "iss_defs.vh"
module iss_top
(
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire [5:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    output wire [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out,
    output wire        irq_out,
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe_out
);
    localparam ST_IDLE   = 2'h0;
    localparam ST_ADDR   = 2'h1;
    localparam ST_DATA   = 2'h2;
    localparam ST_IGNORE = 2'h3;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [1:0]  ctrl_ff;
    reg  [6:0]  own_slave_address_reg_ff;
    reg  [7:0]  serial_bus_status_reg_ff;
    reg  [7:0]  nxt_status;
    reg  [7:0]  rx_data_ff;
    reg  [1:0]  irq_stat_ff;
    reg  [1:0]  irq_mask_ff;
    reg         irq_ff;
    reg         ack_ff;
    reg  [31:0] rdata_ff;
    reg         scl_d_ff;
    reg         sda_d_ff;
    reg         sda_oe_ff;
    reg         nxt_sda_oe;
    reg         exc_ff;
    reg         coi_ff;
    reg         trc_ff;
    reg         std_ff;
    reg         in_frame_ff;
    reg         nxt_exc;
    reg         nxt_coi;
    reg         nxt_trc;
    reg         nxt_std;
    reg         nxt_in_frame;
    reg         byte_evt;
    reg         stop_evt;
    reg         status_upd;

    wire [1:0]  bus_sync;
    wire        scl_s;
    wire        sda_s;
    wire [7:0]  rx_byte;
    wire [3:0]  bit_cnt;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_det;
    wire        stop_det;
    wire        wtim;
    wire        spie;
    wire        is_match;
    wire        is_ext;
    wire        eighth;
    wire        ninth;
    wire        bus_req;
    wire        bus_take;
    wire [3:0]  reg_idx;
    wire [1:0]  irq_set;

    function [7:0] iss_pat;
        input exc;
        input coi;
        input trc;
        input ackd;
        input std;
        begin
            iss_pat = {2'b00, exc, coi, trc, ackd, std, 1'b0};
        end
    endfunction

    iss_sync #(.WIDTH(2)) u_sync
    (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in ({scl_in, sda_in}),
        .sync_out (bus_sync)
    );

    assign scl_s = bus_sync[1];
    assign sda_s = bus_sync[0];

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_ff;
    assign scl_fall  = ~scl_s & scl_d_ff;
    assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    iss_bitcnt u_bitcnt
    (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .clear_in    (start_det | stop_det),
        .scl_rise_in (scl_rise),
        .scl_fall_in (scl_fall),
        .sda_in      (sda_s),
        .byte_out    (rx_byte),
        .cnt_out     (bit_cnt)
    );

    assign wtim     = ctrl_ff[`ISS_CTRL_WTIM];
    assign spie     = ctrl_ff[`ISS_CTRL_SPIE];
    assign is_match = (rx_byte[7:1] == own_slave_address_reg_ff);
    assign is_ext   = (rx_byte[7:3] == `ISS_EXT_PREFIX);
    assign eighth   = scl_fall & (bit_cnt == `ISS_BIT_EIGHTH);
    assign ninth    = scl_fall & (bit_cnt == `ISS_BIT_NINTH);

    // frame sequencer
    always @*
    begin
        nxt_state    = state_ff;
        nxt_status   = serial_bus_status_reg_ff;
        nxt_exc      = exc_ff;
        nxt_coi      = coi_ff;
        nxt_trc      = trc_ff;
        nxt_std      = std_ff;
        nxt_in_frame = in_frame_ff;
        nxt_sda_oe   = sda_oe_ff;
        byte_evt     = 1'b0;
        stop_evt     = 1'b0;
        status_upd   = 1'b0;
        if (stop_det)
        begin
            nxt_state    = ST_IDLE;
            nxt_in_frame = 1'b0;
            nxt_sda_oe   = 1'b0;
            nxt_status   = 8'h01;
            status_upd   = 1'b1;
            stop_evt     = spie;
        end
        else if (start_det)
        begin
            nxt_state  = ST_ADDR;
            nxt_std    = 1'b1;
            nxt_sda_oe = 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_ADDR:
                begin
                    if (eighth)
                    begin
                        if (is_match)
                        begin
                            nxt_exc    = 1'b0;
                            nxt_coi    = 1'b1;
                            nxt_trc    = rx_byte[0];
                            nxt_sda_oe = 1'b1;
                        end
                        else if (is_ext)
                        begin
                            nxt_exc    = 1'b1;
                            nxt_coi    = 1'b0;
                            nxt_trc    = 1'b0;
                            nxt_sda_oe = 1'b1;
                            nxt_status = iss_pat(1'b1, 1'b0, 1'b0,
                                                 1'b0, std_ff);
                            status_upd = 1'b1;
                            byte_evt   = 1'b1;
                        end
                        else
                        begin
                            nxt_exc = 1'b0;
                            nxt_coi = 1'b0;
                            nxt_trc = 1'b0;
                        end
                    end
                    else if (ninth)
                    begin
                        nxt_sda_oe = 1'b0;
                        if (coi_ff)
                        begin
                            nxt_status = iss_pat(1'b0, 1'b1, trc_ff,
                                                 1'b1, std_ff);
                            status_upd = 1'b1;
                            byte_evt   = 1'b1;
                            nxt_state  = ST_DATA;
                        end
                        else if (exc_ff)
                        begin
                            if (wtim)
                            begin
                                nxt_status = iss_pat(1'b1, 1'b0, 1'b0,
                                                     1'b1, std_ff);
                                status_upd = 1'b1;
                                byte_evt   = 1'b1;
                            end
                            nxt_state = ST_DATA;
                        end
                        else
                        begin
                            if (in_frame_ff)
                            begin
                                nxt_status = iss_pat(1'b0, 1'b0, 1'b0,
                                                     1'b0, std_ff);
                                status_upd = 1'b1;
                                byte_evt   = 1'b1;
                            end
                            nxt_state = ST_IGNORE;
                        end
                        nxt_std      = 1'b0;
                        nxt_in_frame = 1'b1;
                    end
                end
                ST_DATA:
                begin
                    if (eighth)
                    begin
                        nxt_sda_oe = ~trc_ff;
                        if (!wtim)
                        begin
                            nxt_status = iss_pat(exc_ff, coi_ff, trc_ff,
                                                 1'b0, 1'b0);
                            status_upd = 1'b1;
                            byte_evt   = 1'b1;
                        end
                    end
                    else if (ninth)
                    begin
                        nxt_sda_oe = 1'b0;
                        if (wtim)
                        begin
                            nxt_status = iss_pat(exc_ff, coi_ff, trc_ff,
                                                 ~trc_ff, 1'b0);
                            status_upd = 1'b1;
                            byte_evt   = 1'b1;
                        end
                    end
                end
                default:
                begin
                    nxt_state = state_ff;
                end
            endcase
        end
    end

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_ff                 <= ST_IDLE;
            serial_bus_status_reg_ff <= `ISS_RST_STATUS;
            exc_ff                   <= 1'b0;
            coi_ff                   <= 1'b0;
            trc_ff                   <= 1'b0;
            std_ff                   <= 1'b0;
            in_frame_ff              <= 1'b0;
            sda_oe_ff                <= 1'b0;
            rx_data_ff               <= 8'h00;
        end
        else
        begin
            state_ff    <= nxt_state;
            exc_ff      <= nxt_exc;
            coi_ff      <= nxt_coi;
            trc_ff      <= nxt_trc;
            std_ff      <= nxt_std;
            in_frame_ff <= nxt_in_frame;
            sda_oe_ff   <= nxt_sda_oe;
            if (status_upd)
                serial_bus_status_reg_ff <= nxt_status;
            if (eighth)
                rx_data_ff <= rx_byte;
        end
    end

    // register slave, one wait cycle per access
    assign bus_req  = avs_read_in | avs_write_in;
    assign bus_take = bus_req & ack_ff;
    assign reg_idx  = avs_address_in[5:2];
    assign irq_set  = {stop_evt, byte_evt};

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ack_ff                   <= 1'b0;
            rdata_ff                 <= 32'h0000_0000;
            ctrl_ff                  <= `ISS_RST_CTRL;
            own_slave_address_reg_ff <= `ISS_RST_OWNADDR;
            irq_mask_ff              <= `ISS_RST_IRQMASK;
            irq_stat_ff              <= 2'h0;
            irq_ff                   <= 1'b0;
        end
        else
        begin
            ack_ff <= bus_req & ~ack_ff;
            if (avs_read_in && !ack_ff)
            begin
                if (reg_idx == `ISS_OFS_CTRL)
                    rdata_ff <= {30'h0, ctrl_ff};
                else if (reg_idx == `ISS_OFS_STATUS)
                    rdata_ff <= {24'h0, serial_bus_status_reg_ff};
                else if (reg_idx == `ISS_OFS_OWNADDR)
                    rdata_ff <= {25'h0, own_slave_address_reg_ff};
                else if (reg_idx == `ISS_OFS_DATA)
                    rdata_ff <= {24'h0, rx_data_ff};
                else if (reg_idx == `ISS_OFS_IRQSTAT)
                    rdata_ff <= {30'h0, irq_stat_ff};
                else if (reg_idx == `ISS_OFS_IRQMASK)
                    rdata_ff <= {30'h0, irq_mask_ff};
                else
                    rdata_ff <= 32'h0000_0000;
            end
            if (bus_take && avs_write_in)
            begin
                if (reg_idx == `ISS_OFS_CTRL)
                    ctrl_ff <= avs_writedata_in[1:0];
                else if (reg_idx == `ISS_OFS_OWNADDR)
                    own_slave_address_reg_ff <= avs_writedata_in[6:0];
                else if (reg_idx == `ISS_OFS_IRQMASK)
                    irq_mask_ff <= avs_writedata_in[1:0];
            end
            // set wins over write-one-to-clear
            if (bus_take && avs_write_in && reg_idx == `ISS_OFS_IRQSTAT)
                irq_stat_ff <= (irq_stat_ff & ~avs_writedata_in[1:0])
                               | irq_set;
            else
                irq_stat_ff <= irq_stat_ff | irq_set;
            irq_ff <= |((irq_stat_ff | irq_set) & irq_mask_ff);
        end
    end

    assign avs_readdata_out    = rdata_ff;
    assign avs_waitrequest_out = ~ack_ff;
    assign irq_out             = irq_ff;
    assign sda_out             = 1'b0;
    assign sda_oe_out          = sda_oe_ff;
endmodule // iss_top

// ==== verilog/iss_defs.vh ====
`ifndef ISS_DEFS_VH
`define ISS_DEFS_VH

// register word offsets, compared with address bits 5:2
`define ISS_OFS_CTRL      4'h0
`define ISS_OFS_STATUS    4'h1
`define ISS_OFS_OWNADDR   4'h2
`define ISS_OFS_DATA      4'h3
`define ISS_OFS_IRQSTAT   4'h4
`define ISS_OFS_IRQMASK   4'h5
`define ISS_ADDR_W        6

// control register fields
`define ISS_CTRL_WTIM     0
`define ISS_CTRL_SPIE     1

// serial bus status register fields
`define ISS_ST_SPD        0
`define ISS_ST_STD        1
`define ISS_ST_ACKD       2
`define ISS_ST_TRC        3
`define ISS_ST_COI        4
`define ISS_ST_EXC        5

// interrupt status / mask fields
`define ISS_IRQ_BYTE      0
`define ISS_IRQ_STOP      1

// reset values
`define ISS_RST_CTRL      2'h0
`define ISS_RST_OWNADDR   7'h00
`define ISS_RST_STATUS    8'h00
`define ISS_RST_IRQMASK   2'h0

// frame timing in scl bit counts
`define ISS_BIT_EIGHTH    4'h8
`define ISS_BIT_NINTH     4'h9

// extension code prefix on the top five address bits
`define ISS_EXT_PREFIX    5'h1E

`endif

// ==== verilog/iss_sync.v ====
`timescale 1ns/10ps
module iss_sync
#(
    parameter WIDTH = 2
)
(
    input  wire             clk_in,
    input  wire             rst_n_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // idle bus level is high
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            meta_ff <= {WIDTH{1'b1}};
            sync_ff <= {WIDTH{1'b1}};
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // iss_sync

// ==== verilog/iss_bitcnt.v ====
`timescale 1ns/10ps
`include "iss_defs.vh"
module iss_bitcnt
(
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire       clear_in,
    input  wire       scl_rise_in,
    input  wire       scl_fall_in,
    input  wire       sda_in,
    output wire [7:0] byte_out,
    output wire [3:0] cnt_out
);
    reg [7:0] byte_ff;
    reg [3:0] cnt_ff;

    // counts rising edges, msb first; wraps after the ninth falling edge
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            byte_ff <= 8'h00;
            cnt_ff  <= 4'h0;
        end
        else if (clear_in)
        begin
            cnt_ff <= 4'h0;
        end
        else if (scl_rise_in)
        begin
            if (cnt_ff < `ISS_BIT_EIGHTH)
                byte_ff <= {byte_ff[6:0], sda_in};
            cnt_ff <= cnt_ff + 4'h1;
        end
        else if (scl_fall_in && cnt_ff == `ISS_BIT_NINTH)
        begin
            cnt_ff <= 4'h0;
        end
    end

    assign byte_out = byte_ff;
    assign cnt_out  = cnt_ff;
endmodule // iss_bitcnt

// ==== sim/iss_top_sva.sv ====
`timescale 1ns/10ps
module iss_chk
(
    input wire        clk_in,
    input wire        rst_n_in,
    input wire [5:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        irq_out,
    input wire        scl_in,
    input wire        sda_in,
    input wire        sda_out,
    input wire        sda_oe_out
);
    reg  [1:0] line_ff;
    reg  [3:0] quiet_ff;
    wire [3:0] nxt_quiet;
    wire       rd_done;
    // cycles since either link line last moved
    assign nxt_quiet = ({scl_in, sda_in} != line_ff) ? 4'h0 :
                       (&quiet_ff) ? quiet_ff : quiet_ff + 4'h1;
    assign rd_done = avs_read_in && !avs_waitrequest_out;
    always @(posedge clk_in)
    begin
        line_ff  <= {scl_in, sda_in};
        quiet_ff <= rst_n_in ? nxt_quiet : 4'hF;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_ack_hold;
        sda_oe_out [*8] ##[4:12] !sda_oe_out;
    endsequence
    property p_wait_one;
        s_req |=> !avs_waitrequest_out;
    endproperty
    property p_wait_pulse;
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    property p_irq_fall;
        $fell(irq_out) |-> $past(avs_write_in) || $past(avs_write_in, 2);
    endproperty
    property p_ack_len;
        $rose(sda_oe_out) |-> s_ack_hold;
    endproperty
    property p_sda_low;
        sda_out == 1'b0;
    endproperty
    property p_irq_link;
        $rose(irq_out) |-> quiet_ff <= 4'h8;
    endproperty
    property p_unmapped;
        rd_done && avs_address_in[5:2] > 4'h5 |-> avs_readdata_out == 32'h0;
    endproperty
    property p_status_shape;
        rd_done && avs_address_in == 6'h04 |->
            avs_readdata_out[31:6] == 26'h0 && !(&avs_readdata_out[5:4]);
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("bus answer not after one wait");
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("bus answer longer than one cycle");
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without a write");
    a_ack_len: assert property (p_ack_len)
        else $error("ack pull not one bus clock");
    a_sda_low: assert property (p_sda_low)
        else $error("sda drive value not low");
    a_irq_link: assert property (p_irq_link)
        else $error("irq not tied to a link edge");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_status_shape: assert property (p_status_shape)
        else $error("status pattern impossible");
endmodule // iss_chk

// ==== sim/iss_mst.sv ====
`timescale 1ns/10ps
module iss_mst
(
    input  wire sda_in,
    output reg  scl_out,
    output reg  sda_out
);
    integer gap;
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        gap     = 0;
    end
    // also a repeated start when scl is low
    task start;
    begin
        #113 sda_out = 1'b1;
        #100 scl_out = 1'b1;
        #100 sda_out = 1'b0;
        #100 scl_out = 1'b0;
    end
    endtask
    task put(input [7:0] b, output ack);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
        begin
            #100 sda_out = b[i];
            #100 scl_out = 1'b1;
            #200 scl_out = 1'b0;
        end
        // long low phase keeps the slave ack away from scl edges
        #100 sda_out = 1'b1;
        #500 scl_out = 1'b1;
        #100 ack = sda_in;
        #100 scl_out = 1'b0;
        #(400 + gap);
    end
    endtask
    task stop;
    begin
        #100 sda_out = 1'b0;
        #100 scl_out = 1'b1;
        #100 sda_out = 1'b1;
        #1000;
    end
    endtask
endmodule // iss_mst

// ==== sim/iss_top_test.sv ====
`timescale 1ns/10ps
module iss_top_test;
    reg         clk_in;
    reg         rst_n_in;
    reg  [5:0]  avs_address_in;
    reg         avs_read_in;
    reg         avs_write_in;
    reg  [31:0] avs_writedata_in;
    wire [31:0] avs_readdata_out;
    wire        avs_waitrequest_out;
    wire        irq_out;
    wire        scl_line;
    wire        sda_drv;
    wire        sda_oe_out;
    wire        sda_line;
    wire        sda_val;
    integer     error_cnt, checked, seed, s, t;
    reg         collect, mk;
    reg  [6:0]  own;
    reg  [31:0] q, r;
    reg  [7:0]  shp;
    reg  [15:0] exp_q[$];
    reg  [7:0]  got_q[$];
    assign sda_line = sda_drv & (~sda_oe_out | sda_val);
    always #25 clk_in = ~clk_in;
    iss_top iss_top_i
    (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
        .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_val),
        .sda_oe_out(sda_oe_out)
    );
    iss_mst iss_mst_i
    (
        .sda_in(sda_line), .scl_out(scl_line), .sda_out(sda_drv)
    );
    task close_out;
    begin
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    task chk(input string nm, input [31:0] e, g, m);
    begin
        checked = checked + 1;
        if (((e ^ g) & m) !== 32'h0)
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e & m, g & m);
        end
    end
    endtask
    task bus(input wr, input [5:0] a, input [31:0] d, output [31:0] rd);
        integer n;
    begin
        @(posedge clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n = n + 1;
        end
        while (avs_waitrequest_out !== 1'b0 && n < 20);
        if (n == 20)
        begin
            error_cnt = error_cnt + 1;
            close_out;
        end
        rd = avs_readdata_out;
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
    end
    endtask
    // status {mask, value} of class k, timing tm, step ph; zero means none
    function [15:0] ev(input [1:0] k, input tm, input [1:0] ph);
        case ({k, tm, ph})
            5'h00, 5'h04: ev = 16'hFF16;
            5'h02: ev = 16'hFF10;
            5'h06: ev = 16'hFB10;
            5'h08, 5'h0C: ev = 16'hFF22;
            5'h0D: ev = 16'hFF26;
            5'h0A: ev = 16'hFF20;
            5'h0E: ev = 16'hFB20;
            5'h10, 5'h14: ev = 16'hFB02;
            default: ev = 16'h0;
        endcase
    endfunction
    task seg_exp(input [1:0] k, input tm, input integer n);
        integer j;
    begin
        for (j = 0; j < n + 2; j = j + 1)
            if (ev(k, tm, j > 1 ? 2'h2 : j[1:0]) != 16'h0)
                exp_q.push_back(ev(k, tm, j > 1 ? 2'h2 : j[1:0]));
    end
    endtask
    task frame(input [1:0] k1, k2, input tm, sp);
        integer   g, j, n;
        reg [1:0] k;
        reg [7:0] a, d;
        reg       ack;
    begin
        r = $random(seed);
        n = r[0] + 1;
        iss_mst_i.gap = r[1] ? 800 : 0;
        bus(1'b1, 6'h00, {30'h0, sp, tm}, q);
        exp_q.delete();
        got_q.delete();
        seg_exp(k1, tm, n);
        if (k2 != 2'h3) seg_exp(k2, tm, n);
        if (sp) exp_q.push_back(16'hFF01);
        if (!mk) exp_q.delete();
        collect = 1'b1;
        fork
            begin
                for (g = 0; g < (k2 == 2'h3 ? 1 : 2); g = g + 1)
                begin
                    k = g ? k2 : k1;
                    a = k[0] ? {5'h1E, r[3:2], 1'b0} : {own ^ {6'h0, k[1]}, 1'b0};
                    iss_mst_i.start();
                    iss_mst_i.put(a, ack);
                    chk("addr_ack", {31'h0, k[1]}, {31'h0, ack}, 1);
                    for (j = 0; j < n; j = j + 1)
                    begin
                        r = $random(seed);
                        d = r[7:0];
                        iss_mst_i.put(d, ack);
                    end
                end
                iss_mst_i.stop();
                collect = 1'b0;
            end
            while (collect)
            begin
                @(posedge clk_in);
                if (irq_out === 1'b1)
                begin
                    bus(1'b0, 6'h04, 32'h0, q);
                    got_q.push_back(q[7:0]);
                    bus(1'b1, 6'h10, 32'h3, q);
                    repeat (2) @(posedge clk_in);
                end
            end
        join
        chk("irq_count", exp_q.size(), got_q.size(), 32'hFF);
        for (j = 0; j < exp_q.size() && j < got_q.size(); j = j + 1)
            chk("status", exp_q[j][7:0], got_q[j], exp_q[j][15:8]);
        bus(1'b0, 6'h0C, 32'h0, q);
        if (k2 != 2'h2) chk("last_byte", d, q, 32'hFF);
    end
    endtask
    initial
    begin
        clk_in = 1'b0;
        rst_n_in = 1'b0;
        avs_address_in = 6'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        error_cnt = 0;
        checked = 0;
        seed = 72107;
        collect = 1'b0;
        mk = 1'b1;
        shp = 8'h9F;
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (s = 0; s < 7; s = s + 1)
            if (s != 3)
            begin
                bus(1'b0, {s[3:0], 2'h0}, 32'h0, q);
                chk("reset_value", 32'h0, q, 32'hFFFFFFFF);
            end
        r = $random(seed);
        own = 7'h10 + {2'h0, r[4:0]};
        bus(1'b1, 6'h08, {25'h0, own}, q);
        bus(1'b1, 6'h14, 32'h3, q);
        for (s = 0; s < 4; s = s + 1)
            for (t = 0; t < 2; t = t + 1)
                frame({1'b0, s == 1}, shp[2*s +: 2], t[0], s[0] ^ t[0]);
        // masked run: events stay pending without an irq
        bus(1'b1, 6'h14, 32'h0, q);
        mk = 1'b0;
        frame(2'h0, 2'h3, 1'b0, 1'b1);
        bus(1'b0, 6'h10, 32'h0, q);
        chk("irq_pending", 32'h3, q, 32'h3);
        bus(1'b1, 6'h10, 32'h3, q);
        bus(1'b0, 6'h10, 32'h0, q);
        chk("irq_cleared", 32'h0, q, 32'h3);
        close_out;
    end
endmodule // iss_top_test
bind iss_top iss_chk iss_chk_i
(
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out)
);
